// ===== common/scp_pkg.sv
// Shared constants for the chained potentiometer serial port.
package scp_pkg;

    // ==========================================================
    // Instruction byte layout: opcode in the top three bits.
    localparam int        OPC_MSB        = 7;
    localparam int        OPC_LSB        = 5;
    localparam int        ADDR_MSB       = 4;
    localparam logic [2:0] OPC_NOP       = 3'h0;
    localparam logic [2:0] OPC_CTRL_RD   = 3'h1;
    localparam logic [2:0] OPC_CTRL_WR   = 3'h3;
    localparam logic [2:0] OPC_ADDR_RD   = 3'h4;
    localparam logic [2:0] OPC_ADDR_WR   = 3'h6;
    localparam logic [2:0] READ_TAG      = 3'h7;

    // ==========================================================
    // Register addresses and reset values.
    localparam logic [4:0] ADDR_WIPER0   = 5'h00;
    localparam logic [4:0] ADDR_WIPER1   = 5'h01;
    localparam logic [4:0] ADDR_ACCESS   = 5'h10;
    localparam logic [7:0] RST_WIPER     = 8'h80;
    localparam logic [7:0] RST_ACCESS    = 8'h40;

    // ==========================================================
    // Access control fields; other bits read as zero.
    localparam int         ACC_SHDN_N_BIT = 6;
    localparam int         ACC_ODRAIN_BIT = 1;
    localparam logic [7:0] ACC_WR_MASK    = 8'h42;

    // ==========================================================
    // Framing and buffering.
    localparam logic [4:0] FRAME_BITS    = 5'h10;
    localparam int         FIFO_DEPTH    = 8;
    localparam int         WORD_BITS     = 16;

endpackage

// ===== verilog/scp_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/100ps
module scp_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clock_in,
    input  wire logic         rst_in,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;   // First stage, read only by the second stage.

    // ==========================================================
    // Both stages reset to zero; only the second stage is visible.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// ===== verilog/scp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module scp_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock and reset.
    input  wire logic         clock_in,
    input  wire logic         rst_in,
    // Filling side.
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    // Draining side.
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic      [W-1:0] out_data_out
);

    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];    // Storage words.
    logic [AW:0]  wr_ptr_r;     // Write pointer with wrap bit.
    logic [AW:0]  rd_ptr_r;     // Read pointer with wrap bit.
    wire          push_w;
    wire          pop_w;
    wire          empty_w;
    wire          full_w;

    // ==========================================================
    // Full when pointers differ only in the wrap bit; D is a power of two.
    assign empty_w       = (wr_ptr_r == rd_ptr_r);
    assign full_w        = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                           (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready_out  = !full_w;
    assign out_valid_out = !empty_w;
    assign out_data_out  = mem_r[rd_ptr_r[AW-1:0]];
    assign push_w        = in_valid_in && !full_w;
    assign pop_w         = out_ready_in && !empty_w;

    // Storage has no reset; only words behind the pointers are ever read.
    always_ff @(posedge clock_in) begin
        if (push_w) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
        end
    end

    // Pointer updates.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule

// ===== verilog/scp_port.sv
// Serial slave port of a dual wiper potentiometer with daisy-chain support.
//
// Functional notes
// R1: Addresses 10000b, 00000b, 00001b select three registers.
// R2: Wiper registers set taps, read back directly.
// R3: Output feeds next device; select, clock shared.
// R4: Host sends chained write frames, last first.
// R5: Captured writes execute on rising select.
// R6: Host sends read frames, then raises select.
// R7: Captured read answers during the next frame.
// R8: Host sends no-operation frames for answers.
// R9: Answer is 111b plus address, then data.
// R10: Mode 0, MSB first, rise in, fall out.
// R11: First byte: three opcode, five address bits.
// R12: Single write takes effect when select rises.
// R13: Single read echoes instruction, data in bytes 3-4.
// R14: Otherwise output repeats input sixteen bits later.
`timescale 1ns/100ps
module scp_port
    import scp_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // Serial pins from the host or the previous chain member.
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_sck_in,
    input  wire logic       spi_sdi_in,
    // Serial output pin as output and enable.
    output logic            spi_sdo_out,
    output logic            spi_sdo_oe_out,
    // Strap: high selects two-frame chained reads.
    input  wire logic       chain_en_in,
    // Register outputs to the analog core.
    output logic      [7:0] wiper0_position_out,
    output logic      [7:0] wiper1_position_out,
    output logic            shutdown_n_out
);

    // ==========================================================
    // Input synchronisation and edge detection.
    // Select enters the synchroniser inverted, so that the zero which the stages
    // hold in reset reads as deselected. A select pin that idles high would
    // otherwise show a false fall and rise, and a driven output, after release.
    logic [3:0] sync_w;         // Synchronised select (high = selected), sck, sdi, chain.
    logic       cs_n_q_r;       // Previous synchronised select.
    logic       sck_q_r;        // Previous synchronised clock.
    wire        cs_n_s_w  = !sync_w[3];
    wire        sck_s_w   = sync_w[2];
    wire        sdi_s_w   = sync_w[1];
    wire        chain_s_w = sync_w[0];

    scp_sync #(.W(4)) u_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in ({!spi_cs_n_in, spi_sck_in, spi_sdi_in, chain_en_in}),
        .sync_out (sync_w)
    );

    wire cs_fall_w  = cs_n_q_r && !cs_n_s_w;
    wire cs_rise_w  = !cs_n_q_r && cs_n_s_w;
    wire sck_rise_w = !sck_q_r && sck_s_w && !cs_n_s_w;
    wire sck_fall_w = sck_q_r && !sck_s_w && !cs_n_s_w;

    // Edge history reads only second-stage outputs.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cs_n_q_r <= 1'b1;
            sck_q_r  <= 1'b0;
        end else begin
            cs_n_q_r <= cs_n_s_w;
            sck_q_r  <= sck_s_w;
        end
    end

    // ==========================================================
    // Registers.
    logic [7:0] wiper0_r;       // First wiper position.
    logic [7:0] wiper1_r;       // Second wiper position.
    logic [7:0] access_r;       // Access control.

    // Read decode shared by both answer paths.
    function automatic logic [7:0] reg_read(input logic [4:0] a, input logic [7:0] w0,
                                            input logic [7:0] w1, input logic [7:0] ac);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_WIPER0: d = w0;   // [R1] [R2]
            ADDR_WIPER1: d = w1;   // [R1] [R2]
            ADDR_ACCESS: d = ac;   // [R1]
            default:     d = 8'h00;
        endcase
        return d;
    endfunction

    // Control opcodes always address the access register.
    function automatic logic [4:0] eff_addr(input logic [7:0] instr);
        logic [2:0] op;
        op = instr[OPC_MSB:OPC_LSB];
        if (op == OPC_CTRL_RD || op == OPC_CTRL_WR) begin
            return ADDR_ACCESS;                             // [R11]
        end
        return instr[ADDR_MSB:0];                           // [R11]
    endfunction

    function automatic logic is_read(input logic [7:0] instr);
        return instr[OPC_MSB:OPC_LSB] == OPC_CTRL_RD ||
               instr[OPC_MSB:OPC_LSB] == OPC_ADDR_RD;       // [R11]
    endfunction

    function automatic logic is_write(input logic [7:0] instr);
        return instr[OPC_MSB:OPC_LSB] == OPC_CTRL_WR ||
               instr[OPC_MSB:OPC_LSB] == OPC_ADDR_WR;       // [R11]
    endfunction

    // ==========================================================
    // Shift stage and frame bookkeeping.
    logic [15:0] shift_r;       // Sixteen-bit pass-through stage.
    logic [4:0]  bit_cnt_r;     // Bits in this frame, saturating at 16.
    logic        pend_r;        // Chained read waiting for the next frame.
    logic [4:0]  pend_addr_r;   // Address of that read.
    logic        sdo_bit_r;     // Serial output bit before pin shaping.

    wire [15:0] shift_nxt_w  = {shift_r[14:0], sdi_s_w};
    wire        bit16_w      = sck_rise_w && (bit_cnt_r == FRAME_BITS - 5'h01);
    // Single-device mode answers within the frame once 16 bits are in.
    wire        single_rd_w  = bit16_w && !chain_s_w && is_read(shift_nxt_w[15:8]);
    wire [7:0]  single_dat_w = reg_read(eff_addr(shift_nxt_w[15:8]),
                                        wiper0_r, wiper1_r, access_r);
    wire        frame_ok_w   = cs_rise_w && (bit_cnt_r == FRAME_BITS);
    wire        chain_load_w = cs_fall_w && pend_r;
    wire [15:0] chain_ans_w  = {READ_TAG, pend_addr_r,
                                reg_read(pend_addr_r, wiper0_r, wiper1_r, access_r)};
    wire [15:0] load_val_w   = chain_load_w ? chain_ans_w : shift_r;

    // Shift on rising clock; answer words replace the stage contents.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            shift_r <= 16'h0000;
        end else if (chain_load_w) begin
            shift_r <= chain_ans_w;                                 // [R7] [R9]
        end else if (single_rd_w) begin
            shift_r <= {shift_nxt_w[15:8], single_dat_w};           // [R13]
        end else if (sck_rise_w) begin
            shift_r <= shift_nxt_w;                                 // [R10] [R14]
        end
    end

    // Bit counter restarts at each select fall.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_r <= 5'h00;
        end else if (cs_fall_w) begin
            bit_cnt_r <= 5'h00;
        end else if (sck_rise_w && bit_cnt_r != FRAME_BITS) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // A read left in the stage at select rise in chain mode is answered next frame.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pend_r      <= 1'b0;
            pend_addr_r <= 5'h00;
        end else if (frame_ok_w && chain_s_w && is_read(shift_r[15:8])) begin
            pend_r      <= 1'b1;                                    // [R7]
            pend_addr_r <= eff_addr(shift_r[15:8]);
        end else if (cs_fall_w) begin
            pend_r      <= 1'b0;
        end
    end

    // Output bit moves on falling clock; first bit shows at select fall.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sdo_bit_r <= 1'b1;
        end else if (cs_fall_w) begin
            sdo_bit_r <= load_val_w[15];                            // [R10]
        end else if (sck_fall_w) begin
            sdo_bit_r <= shift_r[15];                               // [R3] [R10]
        end
    end

    // ==========================================================
    // Pin shaping: released while deselected, low-only in open drain.
    wire odrain_w = access_r[ACC_ODRAIN_BIT];

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            spi_sdo_out    <= 1'b0;
            spi_sdo_oe_out <= 1'b0;
        end else begin
            spi_sdo_out    <= odrain_w ? 1'b0 : sdo_bit_r;
            spi_sdo_oe_out <= !cs_n_s_w && !(odrain_w && sdo_bit_r);   // [R3]
        end
    end

    // ==========================================================
    // Write queue: frames captured at select rise, applied by the drain.
    // A chain answer load reads the registers, so the drain stalls then.
    logic        wq_in_ready_w;
    logic        wq_out_valid_w;
    logic [15:0] wq_out_data_w;
    wire         wq_push_w = frame_ok_w && is_write(shift_r[15:8]);     // [R5] [R12]
    wire         wq_pop_w  = wq_out_valid_w && !chain_load_w;
    wire [4:0]   wq_addr_w = eff_addr(wq_out_data_w[15:8]);
    wire [7:0]   wq_data_w = wq_out_data_w[7:0];

    // Writes arriving with the queue full are dropped; eight frames fit.
    scp_fifo #(.W(WORD_BITS), .D(FIFO_DEPTH)) u_wq (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .in_valid_in   (wq_push_w),
        .in_ready_out  (wq_in_ready_w),
        .in_data_in    (shift_r),
        .out_valid_out (wq_out_valid_w),
        .out_ready_in  (!chain_load_w),
        .out_data_out  (wq_out_data_w)
    );

    // Register updates from the queue.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wiper0_r <= RST_WIPER;
            wiper1_r <= RST_WIPER;
            access_r <= RST_ACCESS;
        end else if (wq_pop_w) begin
            case (wq_addr_w)
                ADDR_WIPER0: wiper0_r <= wq_data_w;                 // [R1] [R2]
                ADDR_WIPER1: wiper1_r <= wq_data_w;                 // [R1] [R2]
                ADDR_ACCESS: access_r <= wq_data_w & ACC_WR_MASK;   // [R1]
                default:     access_r <= access_r;
            endcase
        end
    end

    // Analog core outputs.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wiper0_position_out <= RST_WIPER;
            wiper1_position_out <= RST_WIPER;
            shutdown_n_out      <= RST_ACCESS[ACC_SHDN_N_BIT];
        end else begin
            wiper0_position_out <= wiper0_r;                        // [R2]
            wiper1_position_out <= wiper1_r;                        // [R2]
            shutdown_n_out      <= access_r[ACC_SHDN_N_BIT];
        end
    end

    // ==========================================================
    // Assertions.
    // The wait between the two frames of a chained read has no bound, so the
    // check is split in two steps: the read is held pending, then answered.
    sequence s_read_captured;
        frame_ok_w && chain_s_w && is_read(shift_r[15:8]);
    endsequence

    // The next select fall with a read pending loads the answer word.
    sequence s_answer_loaded;
        cs_fall_w && pend_r;
    endsequence

    a_read_pending: assert property (@(posedge clock_in) disable iff (rst_in) // [R7]
        s_read_captured |=> pend_r)
        else $error("chained read not held for the next frame");

    a_chain_answer_tag: assert property (@(posedge clock_in) disable iff (rst_in) // [R9] [R7]
        s_answer_loaded |=> shift_r[15:13] == READ_TAG &&
        shift_r[12:8] == $past(pend_addr_r))
        else $error("chained answer lacks 111b tag");

    a_shift_in_msb: assert property (@(posedge clock_in) disable iff (rst_in) // [R10] [R14]
        sck_rise_w && !single_rd_w && !chain_load_w |=>
        shift_r == {$past(shift_r[14:0]), $past(sdi_s_w)})
        else $error("stage did not shift in on rising clock");

    a_sdo_on_fall: assert property (@(posedge clock_in) disable iff (rst_in) // [R10] [R3]
        sck_fall_w |=> sdo_bit_r == $past(shift_r[15]) ##1
        spi_sdo_oe_out == !$past(odrain_w && sdo_bit_r))
        else $error("output bit not moved on falling clock");

    a_released_idle: assert property (@(posedge clock_in) disable iff (rst_in) // [R3]
        cs_n_s_w |=> !spi_sdo_oe_out)
        else $error("output driven while deselected");

    a_single_echo: assert property (@(posedge clock_in) disable iff (rst_in) // [R13]
        single_rd_w |=> shift_r[15:8] == $past(shift_nxt_w[15:8]) &&
        shift_r[7:0] == $past(single_dat_w))
        else $error("single read answer wrong");

    a_write_lands: assert property (@(posedge clock_in) disable iff (rst_in) // [R1] [R2]
        wq_pop_w && wq_addr_w == ADDR_WIPER1 |=> wiper1_r == $past(wq_data_w)
        ##1 wiper1_position_out == $past(wiper1_r))
        else $error("wiper write not applied");

    a_write_only_end: assert property (@(posedge clock_in) disable iff (rst_in) // [R12] [R5]
        $changed(wiper0_r) |-> $past(wq_pop_w) &&
        $past(wq_addr_w) == ADDR_WIPER0)
        else $error("wiper changed without a completed write");

    a_write_queued: assert property (@(posedge clock_in) disable iff (rst_in) // [R5] [R11]
        frame_ok_w && is_write(shift_r[15:8]) && wq_in_ready_w |=>
        wq_out_valid_w)
        else $error("completed write frame not queued");

endmodule

// ===== tb/scp_host_model.sv
// Behavioural serial host that frames, clocks and samples the chained link.
`timescale 1ns/100ps
module scp_host_model (
    // Serial pins toward the first chain member.
    output logic      spi_cs_n_out,
    output logic      spi_sck_out,
    output logic      spi_sdi_out,
    // Resolved serial line returning from the chain.
    input  wire logic spi_sdo_in
);
    // ==========================================================
    // Link timing: half of the 125 ns serial period.
    localparam realtime HALF = 62.5;

    // Idle pins: select high and clock low, as mode 0 expects.
    initial begin
        spi_cs_n_out = 1'b1;
        spi_sck_out  = 1'b0; // Clock idles low.
        spi_sdi_out  = 1'b0;
    end

    // ==========================================================
    // One frame: lower select, shift n bits MSB first, sample on each rise.
    // Frames for the last chain member go first, so tx is built that way.
    task automatic xfer(input logic [47:0] tx, input int n, input bit keep,
                        output logic [47:0] rx);
        rx = 48'h0;
        spi_cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spi_sdi_out = tx[i]; // Most significant bit first.
            #HALF;
            spi_sck_out = 1'b1;
            rx = {rx[46:0], spi_sdo_in}; // Sampled on the rising edge.
            #HALF;
            spi_sck_out = 1'b0;
        end
        // The data line is no longer meaningful, so it shows no stale bit.
        spi_sdi_out = ~spi_sdi_out;
        #HALF;
        if (!keep) begin
            end_frame();
        end
    endtask

    // Raise select and keep it high long enough for queued writes to drain.
    task automatic end_frame();
        spi_cs_n_out = 1'b1; // Rising select ends the frame.
        #(2 * HALF);
    endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the chained potentiometer serial port.
`timescale 1ns/100ps
module testbench
    import scp_pkg::*;
();
    // ==========================================================
    // Clock, reset, strap and the two chain members' pins.
    logic        clock_in = 1'b0;
    logic        rst_in   = 1'b1;
    logic        chain_en = 1'b0;  // Single device mode until the chain tests.
    wire         cs_n, sck, sdi;
    logic        sdo0, oe0, sdo1, oe1, sd0, sd1;
    logic [7:0]  w00, w01, w10, w11;
    logic [47:0] rx;
    int          failures   = 0;
    int          n_compared = 0;
    // Pulled-up lines: an undriven output reads as one.
    wire         line0    = oe0 ? sdo0 : 1'b1;
    wire         line1    = oe1 ? sdo1 : 1'b1;
    // The host listens to the end of the chain, or to the first device alone.
    wire         host_sdo = chain_en ? line1 : line0;

    // A 4 ns clock.
    always #2 clock_in = ~clock_in;

    // ==========================================================
    // First member takes host data; its output feeds the second.
    scp_port uut (.clock_in(clock_in), .rst_in(rst_in), .spi_cs_n_in(cs_n),
        .spi_sck_in(sck), .spi_sdi_in(sdi), .spi_sdo_out(sdo0), .spi_sdo_oe_out(oe0),
        .chain_en_in(chain_en), .wiper0_position_out(w00), .wiper1_position_out(w01),
        .shutdown_n_out(sd0));
    scp_port uut_b (.clock_in(clock_in), .rst_in(rst_in), .spi_cs_n_in(cs_n),
        .spi_sck_in(sck), .spi_sdi_in(line0), .spi_sdo_out(sdo1), .spi_sdo_oe_out(oe1),
        .chain_en_in(chain_en), .wiper0_position_out(w10), .wiper1_position_out(w11),
        .shutdown_n_out(sd1));
    scp_host_model host (.spi_cs_n_out(cs_n), .spi_sck_out(sck), .spi_sdi_out(sdi),
        .spi_sdo_in(host_sdo));

    // ==========================================================
    // Comparisons for register levels and for serial words.
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_ser(input logic [47:0] got, input logic [47:0] exp,
                           input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Single device write of one instruction and one data byte.
    task automatic sw(input logic [7:0] ins, input logic [7:0] d);
        host.xfer({32'h0, ins, d}, 16, 1'b0, rx);
    endtask

    // Single device four-byte read; answers land in the last two bytes.
    task automatic sr(input logic [7:0] ins, input logic [15:0] exp, input string what);
        host.xfer({16'h0, ins, 8'h00, 8'h00, 8'h00}, 32, 1'b0, rx);
        chk_ser({32'h0, rx[15:0]}, {32'h0, exp}, what);
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        chk_reg(w00, RST_WIPER, "wiper0 at reset");
        chk_reg(w11, RST_WIPER, "wiper1 at reset");
        chk_reg(w01, RST_WIPER, "first wiper1 at reset");
        chk_reg(w10, RST_WIPER, "second wiper0 at reset");
        chk_reg({7'h0, sd1}, 8'h01, "second running at reset");
        chk_reg({7'h0, sd0}, 8'h01, "running at reset");
        chk_reg({7'h0, oe0}, 8'h00, "output idle at reset");
    endtask

    // The write waits for select to rise, then both wipers read back.
    task automatic t_single_write();
        host.xfer({32'h0, OPC_ADDR_WR, ADDR_WIPER0, 8'h55}, 16, 1'b1, rx);
        repeat (20) @(negedge clock_in);
        chk_reg(w00, RST_WIPER, "wiper0 before select rise");
        host.end_frame();
        chk_reg(w00, 8'h55, "wiper0 after select rise");
        sw({OPC_ADDR_WR, ADDR_WIPER1}, 8'haa);
        chk_reg(w01, 8'haa, "wiper1 written");
        sr({OPC_ADDR_RD, ADDR_WIPER0}, {OPC_ADDR_RD, ADDR_WIPER0, 8'h55}, "wiper0 read");
        sr({OPC_ADDR_RD, ADDR_WIPER1}, {OPC_ADDR_RD, ADDR_WIPER1, 8'haa}, "wiper1 read");
    endtask

    // Short frames, no-operation and unmapped addresses change nothing.
    task automatic t_refused();
        host.xfer({40'h0, OPC_ADDR_WR, ADDR_WIPER0}, 8, 1'b0, rx);
        chk_reg(w00, 8'h55, "short frame ignored");
        sw({OPC_NOP, ADDR_WIPER0}, 8'h12);
        chk_reg(w00, 8'h55, "no-operation ignored");
        sw({OPC_ADDR_WR, 5'h03}, 8'h11);
        chk_reg(w01, 8'haa, "unmapped write ignored");
        sr({OPC_ADDR_RD, 5'h03}, {OPC_ADDR_RD, 5'h03, 8'h00}, "unmapped read");
    endtask

    // Access register by both opcode families; only two bits are kept.
    task automatic t_access();
        sw({OPC_CTRL_WR, 5'h00}, 8'h00);
        chk_reg({7'h0, sd0}, 8'h00, "shutdown entered");
        sr({OPC_CTRL_RD, 5'h00}, {OPC_CTRL_RD, 5'h00, 8'h00}, "access read");
        sw({OPC_ADDR_WR, ADDR_ACCESS}, 8'hff);
        chk_reg({7'h0, sd0}, 8'h01, "shutdown left");
        // The output is open drain now; the pull-up supplies the ones.
        sr({OPC_ADDR_RD, ADDR_ACCESS}, {OPC_ADDR_RD, ADDR_ACCESS, ACC_WR_MASK},
           "access mask");
        sw({OPC_ADDR_WR, ADDR_ACCESS}, RST_ACCESS);
    endtask

    // Chained write: last member's frame first, both act on one select rise.
    task automatic t_chain_write();
        @(negedge clock_in);
        chain_en = 1'b1;
        repeat (4) @(negedge clock_in);
        host.xfer({16'h0, OPC_ADDR_WR, ADDR_WIPER1, 8'ha5, OPC_ADDR_WR, ADDR_WIPER0, 8'h3c},
                  32, 1'b0, rx);
        chk_reg(w11, 8'ha5, "second member wiper1");
        chk_reg(w00, 8'h3c, "first member wiper0");
    endtask

    // Chained read in two frames; tagged address byte, then data.
    task automatic t_chain_read();
        host.xfer({16'h0, OPC_ADDR_RD, ADDR_WIPER1, 8'h00, OPC_ADDR_RD, ADDR_WIPER0, 8'h00},
                  32, 1'b0, rx);
        host.xfer(48'h0, 32, 1'b0, rx);
        chk_ser({16'h0, rx[31:0]}, {16'h0, READ_TAG, ADDR_WIPER1, 8'ha5,
                 READ_TAG, ADDR_WIPER0, 8'h3c}, "chained answers");
    endtask

    // Without a read pending the chain is a 32-bit delay line.
    task automatic t_pass();
        host.xfer(48'h0011_0022_0033, 48, 1'b0, rx);
        chk_ser({32'h0, rx[15:0]}, 48'h0011, "pass-through");
        chk_reg(w00, 8'h3c, "no-operation frames harmless");
    endtask

    // ==========================================================
    // Verdict and end of run.
    task automatic conclude();
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset for six cycles, then allow the pin synchronisers to settle.
    initial begin
        repeat (6) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clock_in);
        t_reset();
        t_single_write();
        t_refused();
        t_access();
        t_chain_write();
        t_chain_read();
        t_pass();
        conclude();
    end

    // Watchdog: the tests need well under 100 us, so 200 us means a hang.
    initial begin
        #200000;
        failures++;
        conclude();
    end
endmodule
